/* hdl/ascr_regs.svh */
// Purpose: register offsets, field positions, reset values and codes of the config bank
// Assumes: 8-bit registers addressed by the low byte of the serial address
// Notes: definitions only
`ifndef ASCR_REGS_SVH
`define ASCR_REGS_SVH
// register offsets
`define ASCR_A_PORT_CFG 8'h00
`define ASCR_A_BURST_LAST 8'h02
`define ASCR_A_DIE_ID 8'h08
`define ASCR_A_DIE_REV 8'h09
`define ASCR_A_CONV_SEL 8'h10
`define ASCR_A_OFS_COARSE 8'h20
`define ASCR_A_OFS_FINE 8'h21
`define ASCR_A_GAIN_COARSE 8'h22
`define ASCR_A_GAIN_MEDIUM 8'h23
`define ASCR_A_GAIN_FINE 8'h24
`define ASCR_A_PWR_SEL 8'h25
`define ASCR_A_CLK_ADV 8'h71
`define ASCR_A_DIV_SEL 8'h72
`define ASCR_A_DRV_CODE 8'h73
`define ASCR_A_DDR_DLL 8'h74
`define ASCR_A_CFG_STATE 8'h75
`define ASCR_A_TEST_CTRL 8'hC0
`define ASCR_A_PAT1_LO 8'hC2
`define ASCR_A_PAT1_HI 8'hC3
`define ASCR_A_PAT2_LO 8'hC4
`define ASCR_A_PAT2_HI 8'hC5
// field positions
`define ASCR_B_SEP_OUT 7
`define ASCR_B_LSB_FIRST 6
`define ASCR_B_SOFT_RST 5
`define ASCR_B_DLL_SLOW 6
// reset values and fixed bytes
`define ASCR_RST_BYTE 8'h00
`define ASCR_ERR_BYTE 8'hAD
`define ASCR_DIE_ID_VAL 8'h5A // arbitrary value
`define ASCR_DIE_REV_VAL 8'h01 // arbitrary value
// three-bit mode codes
`define ASCR_C_PIN 3'h0
`define ASCR_C_ONE 3'h1
`define ASCR_C_TWO 3'h2
`define ASCR_C_FOUR 3'h4
// test pattern codes and words
`define ASCR_T_OFF 4'h0
`define ASCR_T_MID 4'h1
`define ASCR_T_POS 4'h2
`define ASCR_T_NEG 4'h3
`define ASCR_T_CHECK 4'h4
`define ASCR_T_ONEZERO 4'h7
`define ASCR_T_USER 4'h8
`define ASCR_W_MID 16'h8000
`define ASCR_W_ONES 16'hFFFF
`define ASCR_W_ZEROS 16'h0000
`define ASCR_W_CHK1 16'hAAAA
`define ASCR_W_CHK2 16'h5555
// serial framing
`define ASCR_INSTR_LAST 4'hF
`define ASCR_BYTE_LAST 3'h7
`define ASCR_BC_MANY 2'h3
`endif

/* hdl/ascr_pkg.sv */
// Purpose: types shared by the config bank
// Assumes: tri-level pins arrive decoded as low, float or high
// Notes: none
package ascr_pkg;
   // decoded tri-level pin level
   typedef enum logic [1:0] {
      ASCR_LVL_LOW = 2'h0,
      ASCR_LVL_FLOAT = 2'h1,
      ASCR_LVL_HIGH = 2'h2
   } ascr_level_t;
   // mode pins
   typedef struct packed {
      ascr_level_t power_state_pin;
      ascr_level_t divider_pin;
      ascr_level_t driver_pin;
      ascr_level_t coding_pin;
   } ascr_pins_t;
   // effective controls handed to the converter core, one-hot mode codes
   typedef struct packed {
      logic [2:0] power_mode;
      logic [2:0] divide;
      logic [2:0] driver;
      logic [2:0] coding;
      logic dll_slow;
      logic [7:0] ddr_dll;
   } ascr_ctrl_t;
   // calibration results of the power-up trim
   typedef struct packed {
      logic [7:0] ofs_coarse;
      logic [7:0] ofs_fine;
      logic [3:0] gain_coarse;
      logic [7:0] gain_medium;
      logic [7:0] gain_fine;
   } ascr_trim_t;
   // serial engine states
   typedef enum logic [2:0] {
      ASCR_ST_IDLE = 3'b001,
      ASCR_ST_INSTR = 3'b010,
      ASCR_ST_DATA = 3'b100
   } ascr_state_t;
endpackage : ascr_pkg

/* hdl/ascr_bank.sv */
// Purpose: serial-port configuration register bank of a 12-bit converter
// Assumes: serial pins are synchronous to mclk, which runs well above the serial clock
// Notes: test pattern alternation steps once per mclk cycle
`include "ascr_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module ascr_bank import ascr_pkg::*; (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // serial port
   input wire logic select_bar,
   input wire logic sclk,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   output logic sdo_out,
   output logic sdo_oe,
   // mode pins, calibration and status
   input wire ascr_pins_t pins,
   input wire ascr_trim_t cal,
   input wire logic [7:0] cfg_state_in,
   // to the converter core
   output ascr_ctrl_t ctrl,
   output logic [15:0] trim_offset,
   output logic [27:0] trim_gain,
   output logic slip_pulse,
   output logic test_on,
   output logic [15:0] test_word
);
   ascr_state_t state_reg;
   logic sclk_q, rise;
   logic [15:0] shift_reg, shift_next;
   logic [3:0] cnt_reg;
   logic rd_reg, burst_reg, done_reg;
   logic [1:0] bc_reg, nbytes_reg;
   logic [12:0] addr_reg, look_addr;
   logic [7:0] out_reg, rd_byte, in_byte;
   logic instr_end, byte_end, wr_stb, load_rd, soft_rst, sel;
   logic [7:0] port_reg, burst_last_reg, conv_sel_reg, adv_reg, ddr_dll_reg;
   logic [7:0] ofs_c_reg, ofs_f_reg, gain_m_reg, gain_f_reg, test_ctrl_reg;
   logic [3:0] gain_c_reg;
   logic [2:0] pd_reg, div_reg, drv_reg, code_reg;
   logic [7:0] p1l_reg, p1h_reg, p2l_reg, p2h_reg;
   logic phase_reg;
   logic lsb_first;
   logic [7:0] a8;

   // serial clock edges and next shift value
   assign rise = sclk & ~sclk_q;
   assign lsb_first = port_reg[`ASCR_B_LSB_FIRST];
   assign shift_next = lsb_first ? {sdio_in, shift_reg[15:1]}
                                 : {shift_reg[14:0], sdio_in};
   assign in_byte = lsb_first ? shift_next[15:8] : shift_next[7:0];
   assign instr_end = (state_reg == ASCR_ST_INSTR) && rise && (cnt_reg == `ASCR_INSTR_LAST);
   assign byte_end = (state_reg == ASCR_ST_DATA) && rise && !done_reg
                     && (cnt_reg[2:0] == `ASCR_BYTE_LAST);
   assign wr_stb = byte_end && !rd_reg;
   assign load_rd = (instr_end && shift_next[15]) || (byte_end && rd_reg);
   assign a8 = addr_reg[7:0];
   assign look_addr = instr_end ? shift_next[12:0] : addr_reg + (lsb_first ? 13'h1FFF : 13'h0001);
   assign sel = conv_sel_reg[0];
   assign soft_rst = wr_stb && (a8 == `ASCR_A_PORT_CFG) && (addr_reg[12:8] == 5'h00)
                     && in_byte[`ASCR_B_SOFT_RST];
   // sclk delay for edge detection
   always_ff @(posedge mclk) begin
      if (rst) begin
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= sclk;
      end
   end

   // serial engine: instruction, data bytes, address stepping, burst end
   always_ff @(posedge mclk) begin
      if (rst || select_bar) begin
         state_reg <= ASCR_ST_IDLE;
         cnt_reg <= 4'h0;
         shift_reg <= 16'h0000;
         rd_reg <= 1'b0;
         burst_reg <= 1'b0;
         bc_reg <= 2'h0;
         nbytes_reg <= 2'h0;
         addr_reg <= 13'h0000;
         done_reg <= 1'b0;
      end else begin
         case (state_reg)
            ASCR_ST_IDLE: begin
               state_reg <= ASCR_ST_INSTR;
               cnt_reg <= 4'h0;
            end
            ASCR_ST_INSTR: begin
               if (rise) begin
                  shift_reg <= shift_next;
                  cnt_reg <= cnt_reg + 4'h1;
               end
               if (instr_end) begin
                  rd_reg <= shift_next[15];
                  bc_reg <= shift_next[14:13];
                  burst_reg <= (shift_next[14:13] == `ASCR_BC_MANY);
                  addr_reg <= shift_next[12:0];
                  nbytes_reg <= 2'h0;
                  state_reg <= ASCR_ST_DATA;
               end
            end
            ASCR_ST_DATA: begin
               if (rise && !done_reg) begin
                  shift_reg <= shift_next;
                  cnt_reg <= cnt_reg + 4'h1;
               end
               if (byte_end) begin
                  nbytes_reg <= nbytes_reg + 2'h1;
                  if (burst_reg ? (a8 == burst_last_reg) : (nbytes_reg == bc_reg)) begin
                     done_reg <= 1'b1;
                  end else if (lsb_first) begin
                     addr_reg <= addr_reg - 13'h0001;
                  end else begin
                     addr_reg <= addr_reg + 13'h0001;
                  end
               end
            end
            default: state_reg <= ASCR_ST_IDLE;
         endcase
      end
   end

   // read lookup at the next byte's address; unselected indexed registers give the error byte
   always_comb begin
      rd_byte = 8'h00;
      if (look_addr[12:8] == 5'h00) begin
         case (look_addr[7:0])
            `ASCR_A_PORT_CFG: rd_byte = {port_reg[7:6], 4'h0, port_reg[6], port_reg[7]};
            `ASCR_A_BURST_LAST: rd_byte = burst_last_reg;
            `ASCR_A_DIE_ID: rd_byte = `ASCR_DIE_ID_VAL;
            `ASCR_A_DIE_REV: rd_byte = `ASCR_DIE_REV_VAL;
            `ASCR_A_CONV_SEL: rd_byte = conv_sel_reg;
            `ASCR_A_OFS_COARSE: rd_byte = sel ? ofs_c_reg : `ASCR_ERR_BYTE;
            `ASCR_A_OFS_FINE: rd_byte = sel ? ofs_f_reg : `ASCR_ERR_BYTE;
            `ASCR_A_GAIN_COARSE: rd_byte = sel ? {4'h0, gain_c_reg} : `ASCR_ERR_BYTE;
            `ASCR_A_GAIN_MEDIUM: rd_byte = sel ? gain_m_reg : `ASCR_ERR_BYTE;
            `ASCR_A_GAIN_FINE: rd_byte = sel ? gain_f_reg : `ASCR_ERR_BYTE;
            `ASCR_A_PWR_SEL: rd_byte = sel ? {5'h00, pd_reg} : `ASCR_ERR_BYTE;
            `ASCR_A_CLK_ADV: rd_byte = adv_reg;
            `ASCR_A_DIV_SEL: rd_byte = {5'h00, div_reg};
            `ASCR_A_DRV_CODE: rd_byte = {drv_reg, 2'h0, code_reg};
            `ASCR_A_DDR_DLL: rd_byte = ddr_dll_reg;
            `ASCR_A_CFG_STATE: rd_byte = cfg_state_in;
            `ASCR_A_TEST_CTRL: rd_byte = test_ctrl_reg;
            `ASCR_A_PAT1_LO: rd_byte = p1l_reg;
            `ASCR_A_PAT1_HI: rd_byte = p1h_reg;
            `ASCR_A_PAT2_LO: rd_byte = p2l_reg;
            `ASCR_A_PAT2_HI: rd_byte = p2h_reg;
            default: rd_byte = 8'h00;
         endcase
      end
   end

   // outgoing byte: loaded when the byte starts, held for its eight bits
   always_ff @(posedge mclk) begin
      if (rst) begin
         out_reg <= 8'h00;
      end else if (load_rd) begin
         out_reg <= rd_byte;
      end
   end
   // pin drive: the bit for the next rise is picked by the rises seen in this byte
   assign sdio_out = lsb_first ? out_reg[cnt_reg[2:0]] : out_reg[~cnt_reg[2:0]];
   assign sdo_out = sdio_out;
   assign sdo_oe = rd_reg && (state_reg == ASCR_ST_DATA) && port_reg[`ASCR_B_SEP_OUT];
   assign sdio_oe = rd_reg && (state_reg == ASCR_ST_DATA) && !port_reg[`ASCR_B_SEP_OUT];

   // global port registers, cleared by soft reset
   always_ff @(posedge mclk) begin
      if (rst || soft_rst) begin
         port_reg <= `ASCR_RST_BYTE;
         burst_last_reg <= `ASCR_RST_BYTE;
         conv_sel_reg <= `ASCR_RST_BYTE;
         adv_reg <= `ASCR_RST_BYTE;
         ddr_dll_reg <= `ASCR_RST_BYTE;
      end else if (wr_stb && (addr_reg[12:8] == 5'h00)) begin
         case (a8)
            `ASCR_A_PORT_CFG: port_reg <= {in_byte[7:6], 6'h00};
            `ASCR_A_BURST_LAST: burst_last_reg <= in_byte;
            `ASCR_A_CONV_SEL: conv_sel_reg <= in_byte;
            `ASCR_A_CLK_ADV: adv_reg <= in_byte;
            `ASCR_A_DDR_DLL: ddr_dll_reg <= in_byte;
            default: ;
         endcase
      end
   end

   // indexed trims: default is the calibration result
   always_ff @(posedge mclk) begin
      if (rst || soft_rst) begin
         ofs_c_reg <= cal.ofs_coarse;
         ofs_f_reg <= cal.ofs_fine;
         gain_c_reg <= cal.gain_coarse;
         gain_m_reg <= cal.gain_medium;
         gain_f_reg <= cal.gain_fine;
      end else if (wr_stb && sel && (addr_reg[12:8] == 5'h00)) begin
         case (a8)
            `ASCR_A_OFS_COARSE: ofs_c_reg <= in_byte;
            `ASCR_A_OFS_FINE: ofs_f_reg <= in_byte;
            `ASCR_A_GAIN_COARSE: gain_c_reg <= in_byte[3:0];
            `ASCR_A_GAIN_MEDIUM: gain_m_reg <= in_byte;
            `ASCR_A_GAIN_FINE: gain_f_reg <= in_byte;
            default: ;
         endcase
      end
   end

   // mode registers survive soft reset; reserved codes leave them unchanged
   always_ff @(posedge mclk) begin
      if (rst) begin
         pd_reg <= `ASCR_C_PIN;
         div_reg <= `ASCR_C_PIN;
         drv_reg <= `ASCR_C_PIN;
         code_reg <= `ASCR_C_PIN;
      end else if (wr_stb && (addr_reg[12:8] == 5'h00)) begin
         if (a8 == `ASCR_A_PWR_SEL && sel && legal(in_byte[2:0])) begin
            pd_reg <= in_byte[2:0];
         end
         if (a8 == `ASCR_A_DIV_SEL && legal(in_byte[2:0])) begin
            div_reg <= in_byte[2:0];
         end
         if (a8 == `ASCR_A_DRV_CODE && legal(in_byte[7:5])) begin
            drv_reg <= in_byte[7:5];
         end
         if (a8 == `ASCR_A_DRV_CODE && legal(in_byte[2:0])) begin
            code_reg <= in_byte[2:0];
         end
      end
   end

   // test pattern registers; reserved pattern codes and writes with bit 7 set are dropped
   always_ff @(posedge mclk) begin
      if (rst || soft_rst) begin
         test_ctrl_reg <= `ASCR_RST_BYTE;
         p1l_reg <= `ASCR_RST_BYTE;
         p1h_reg <= `ASCR_RST_BYTE;
         p2l_reg <= `ASCR_RST_BYTE;
         p2h_reg <= `ASCR_RST_BYTE;
      end else if (wr_stb && (addr_reg[12:8] == 5'h00)) begin
         case (a8)
            `ASCR_A_TEST_CTRL: begin
               if (!in_byte[7] && (in_byte[3:0] <= `ASCR_T_USER)
                   && (in_byte[3:0] != 4'h5) && (in_byte[3:0] != 4'h6)) begin
                  test_ctrl_reg <= {in_byte[7:6], 2'h0, in_byte[3:0]};
               end
            end
            `ASCR_A_PAT1_LO: p1l_reg <= in_byte;
            `ASCR_A_PAT1_HI: p1h_reg <= in_byte;
            `ASCR_A_PAT2_LO: p2l_reg <= in_byte;
            `ASCR_A_PAT2_HI: p2h_reg <= in_byte;
            default: ;
         endcase
      end
   end

   // divided clock advance: a one-cycle pulse on a zero-then-one write of bit 0
   always_ff @(posedge mclk) begin
      if (rst) begin
         phase_reg <= 1'b0;
         slip_pulse <= 1'b0;
      end else begin
         slip_pulse <= 1'b0;
         if (wr_stb && (addr_reg[12:8] == 5'h00) && (a8 == `ASCR_A_CLK_ADV)) begin
            phase_reg <= in_byte[0];
            slip_pulse <= in_byte[0] && !phase_reg;
         end
      end
   end

   // test word generation, alternating each cycle in alternate mode
   logic alt_reg;
   logic [15:0] w1, w2;
   always_comb begin
      w1 = `ASCR_W_ZEROS;
      w2 = `ASCR_W_ZEROS;
      case (test_ctrl_reg[3:0])
         `ASCR_T_MID: begin
            w1 = `ASCR_W_MID;
            w2 = `ASCR_W_MID;
         end
         `ASCR_T_POS: begin
            w1 = `ASCR_W_ONES;
            w2 = `ASCR_W_ONES;
         end
         `ASCR_T_CHECK: begin
            w1 = `ASCR_W_CHK1;
            w2 = `ASCR_W_CHK2;
         end
         `ASCR_T_ONEZERO: w1 = `ASCR_W_ONES;
         `ASCR_T_USER: begin
            w1 = {p1h_reg, p1l_reg};
            w2 = {p2h_reg, p2l_reg};
         end
         default: w1 = `ASCR_W_ZEROS;
      endcase
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         alt_reg <= 1'b0;
         test_on <= 1'b0;
         test_word <= 16'h0000;
      end else begin
         alt_reg <= test_ctrl_reg[6] ? ~alt_reg : 1'b0;
         test_on <= (test_ctrl_reg[3:0] != `ASCR_T_OFF);
         test_word <= alt_reg ? w2 : w1;
      end
   end

   // effective controls: register code, or pin when the code is zero
   always_comb begin
      ctrl = '0;
      ctrl.power_mode = (pd_reg != `ASCR_C_PIN) ? pd_reg
         : (pins.power_state_pin == ASCR_LVL_LOW) ? `ASCR_C_ONE
         : (pins.power_state_pin == ASCR_LVL_HIGH) ? `ASCR_C_TWO : `ASCR_C_FOUR;
      ctrl.divide = (div_reg != `ASCR_C_PIN) ? div_reg : pin_code(pins.divider_pin);
      ctrl.driver = (drv_reg != `ASCR_C_PIN) ? drv_reg : pin_code(pins.driver_pin);
      ctrl.coding = (code_reg != `ASCR_C_PIN) ? code_reg
         : (pins.coding_pin == ASCR_LVL_LOW) ? `ASCR_C_FOUR
         : (pins.coding_pin == ASCR_LVL_HIGH) ? `ASCR_C_TWO : `ASCR_C_ONE;
      ctrl.dll_slow = ddr_dll_reg[`ASCR_B_DLL_SLOW];
      ctrl.ddr_dll = ddr_dll_reg;
   end
   assign trim_offset = {ofs_c_reg, ofs_f_reg};
   assign trim_gain = {gain_c_reg, gain_m_reg, gain_f_reg, 8'h00};
   // legal mode codes
   function automatic logic legal(input logic [2:0] c);
      legal = (c == `ASCR_C_PIN) || (c == `ASCR_C_ONE) || (c == `ASCR_C_TWO)
              || (c == `ASCR_C_FOUR);
   endfunction : legal
   // pin level to mode code: low one, float two, high four
   function automatic logic [2:0] pin_code(input ascr_level_t l);
      pin_code = (l == ASCR_LVL_LOW) ? `ASCR_C_ONE
               : (l == ASCR_LVL_FLOAT) ? `ASCR_C_TWO : `ASCR_C_FOUR;
   endfunction : pin_code
   // checks
   sequence seq_adv_write;
      wr_stb && (addr_reg == 13'h0071) && in_byte[0] && !phase_reg;
   endsequence
   sequence seq_one_pulse;
      slip_pulse ##1 !slip_pulse;
   endsequence
   chk_slip_pulse: assert property (@(posedge mclk) disable iff (rst)
      seq_adv_write |=> seq_one_pulse) else $error("advance pulse missing");
   chk_index_reset: assert property (@(posedge mclk)
      rst |=> conv_sel_reg == 8'h00) else $error("index not cleared");
   chk_err_byte: assert property (@(posedge mclk) disable iff (rst)
      load_rd && !sel && (look_addr >= 13'h0020) && (look_addr <= 13'h0025)
      |=> out_reg == 8'hAD) else $error("error byte missing");
   chk_soft_keep: assert property (@(posedge mclk) disable iff (rst)
      soft_rst |=> $stable(pd_reg) && $stable(div_reg) && port_reg == 8'h00)
      else $error("soft reset wrong");
   chk_pd_reserved: assert property (@(posedge mclk) disable iff (rst)
      wr_stb && (addr_reg == 13'h0025) && (in_byte[2:0] == 3'h3) |=> $stable(pd_reg))
      else $error("reserved code taken");
   chk_div_override: assert property (@(posedge mclk) disable iff (rst)
      div_reg != 3'h0 |-> ctrl.divide == div_reg) else $error("divider not overridden");
   chk_check_words: assert property (@(posedge mclk) disable iff (rst)
      (test_ctrl_reg == 8'h04) [*2] |=> test_word == 16'hAAAA)
      else $error("checkerboard word wrong");
   chk_addr_step: assert property (@(posedge mclk) disable iff (rst || select_bar)
      byte_end && !lsb_first && burst_reg && (a8 != burst_last_reg)
      |=> addr_reg == $past(addr_reg) + 13'h0001) else $error("address not stepped");
   chk_select_end: assert property (@(posedge mclk) disable iff (rst)
      select_bar |=> state_reg == ASCR_ST_IDLE ##1 !sdio_oe) else $error("frame not ended");
endmodule : ascr_bank
`default_nettype wire

/* tb/ascr_master.sv */
// Purpose: serial master model that drives the config bank port
// Assumes: sclk stays low 2 mclk and high 3 mclk per bit
// Notes: a released data line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module ascr_master (
   // clock
   input wire logic mclk,
   // serial port
   output logic select_bar,
   output logic sclk,
   output logic sdio_in,
   input wire logic sdio_out
);
   logic [7:0] wbuf [8];
   logic [7:0] rbuf [8];
   // idle: deselected, clock parked low
   initial begin
      select_bar = 1'b1;
      sclk = 1'b0;
      sdio_in = 1'b0;
   end
   // one bit: data set while sclk low, reply sampled just before the rise
   task automatic bit_io(input logic b, output logic r);
      sdio_in = b;
      repeat (2) @(posedge mclk);
      #1 r = sdio_out;
      sclk = 1'b1;
      repeat (3) @(posedge mclk);
      #1 sclk = 1'b0;
   endtask : bit_io
   // instruction, then exactly n bytes, then release
   task automatic frame(input logic rw, input logic [1:0] bc, input logic [12:0] adr,
         input int n, input logic lsb);
      logic [15:0] ins;
      logic r;
      ins = {rw, bc, adr};
      @(posedge mclk);
      #1 select_bar = 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      for (int i = 0; i < 16; i++) bit_io(lsb ? ins[i] : ins[15-i], r);
      for (int b = 0; b < n; b++) begin
         for (int i = 0; i < 8; i++) begin
            bit_io(lsb ? wbuf[b][i] : wbuf[b][7-i], r);
            rbuf[b][lsb ? i : 7-i] = r;
         end
      end
      @(posedge mclk);
      #1 select_bar = 1'b1;
      sdio_in = ~sdio_in;
      repeat (3) @(posedge mclk);
   endtask : frame
endmodule : ascr_master
`default_nettype wire

/* tb/tb.sv */
// Purpose: self-checking bench of the config register bank
// Assumes: all mode pins low; serial master model drives the port
// Notes: random values come from a bench shift register
`include "ascr_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb import ascr_pkg::*;;
   logic mclk, rst, select_bar, sclk, sdio_in, sdio_out, sdio_oe, sdo_out, sdo_oe;
   logic slip_pulse, test_on, sdo_seen, sdio_seen;
   logic [7:0] cfg_state_in;
   logic [15:0] trim_offset, test_word, rnd;
   logic [27:0] trim_gain;
   ascr_pins_t pins;
   ascr_trim_t cal;
   ascr_ctrl_t ctrl;
   int err_total, num_checks, slips;
   ascr_bank dut_u (.mclk, .rst, .select_bar, .sclk, .sdio_in, .sdio_out, .sdio_oe, .sdo_out,
      .sdo_oe, .pins, .cal, .cfg_state_in, .ctrl, .trim_offset, .trim_gain, .slip_pulse,
      .test_on, .test_word);
   ascr_master m_u (.mclk, .select_bar, .sclk, .sdio_in, .sdio_out(sdo_oe ? sdo_out : sdio_out));
   // clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // count slip pulses and note which data pin was enabled
   always @(posedge mclk) begin
      if (slip_pulse === 1'b1) slips <= slips + 1;
      if (sdo_oe === 1'b1) sdo_seen <= 1'b1;
      if (sdio_oe === 1'b1) sdio_seen <= 1'b1;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // expected effective code: pin value when the register code is zero
   function automatic logic [2:0] pick(input logic [2:0] c, input logic [2:0] p);
      return (c == 3'h0) ? p : c;
   endfunction : pick
   // expected word pair of a test control byte
   function automatic logic [31:0] patw(input logic [7:0] t, input logic [31:0] u);
      logic [31:0] p;
      case (t[3:0])
         `ASCR_T_MID: p = {`ASCR_W_MID, `ASCR_W_MID};
         `ASCR_T_POS: p = {`ASCR_W_ONES, `ASCR_W_ONES};
         `ASCR_T_NEG: p = {`ASCR_W_ZEROS, `ASCR_W_ZEROS};
         `ASCR_T_CHECK: p = {`ASCR_W_CHK1, `ASCR_W_CHK2};
         `ASCR_T_ONEZERO: p = {`ASCR_W_ONES, `ASCR_W_ZEROS};
         default: p = u;
      endcase
      // static mode shows word one only
      return t[6] ? p : {p[31:16], p[31:16]};
   endfunction : patw
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic lsb = 1'b0);
      m_u.wbuf[0] = d;
      m_u.frame(1'b0, 2'h0, {5'h00, a}, 1, lsb);
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic lsb = 1'b0);
      m_u.frame(1'b1, 2'h0, {5'h00, a}, 1, lsb);
      chk(m_u.rbuf[0], e);
   endtask : rchk
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude
   // watchdog
   initial begin
      #400000;
      err_total++;
      $display("unexpected at %0t: watchdog expired", $time);
      conclude();
   end
   // main sequence
   initial begin
      logic [7:0] a, b;
      logic [15:0] wa, wb;
      logic [31:0] u;
      logic [2:0] c;
      logic [7:0] tc [8];
      tc = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h44, 8'h47, 8'h48, 8'h08};
      rnd = lfsr(16'h8773);
      cal = {rnd, ~rnd, rnd[3:0]};
      cfg_state_in = rnd[15:8];
      pins = '0;
      rst = 1'b1;
      {sdo_seen, sdio_seen, slips, err_total, num_checks} = '0;
      repeat (3) @(posedge mclk);
      #1 rst = 1'b0;
      repeat (2) @(posedge mclk);
      rchk(`ASCR_A_PORT_CFG, 8'h00);
      rchk(`ASCR_A_CONV_SEL, 8'h00);
      rchk(`ASCR_A_OFS_COARSE, `ASCR_ERR_BYTE);
      chk(trim_offset, {cal.ofs_coarse, cal.ofs_fine});
      wr(`ASCR_A_DIE_ID, 8'h00);
      rchk(`ASCR_A_DIE_ID, `ASCR_DIE_ID_VAL);
      rchk(`ASCR_A_DIE_REV, `ASCR_DIE_REV_VAL);
      $display("test defaults done");
      wr(`ASCR_A_CONV_SEL, 8'h01);
      rchk(`ASCR_A_OFS_COARSE, cal.ofs_coarse);
      for (int i = 0; i < 3; i++) begin
         rnd = (i == 0) ? 16'hFF00 : lfsr(rnd);
         wr(`ASCR_A_OFS_COARSE, rnd[7:0]);
         wr(`ASCR_A_GAIN_COARSE, {4'h0, rnd[11:8]});
         wr(`ASCR_A_GAIN_MEDIUM, rnd[15:8]);
         wr(`ASCR_A_GAIN_FINE, rnd[7:0]);
         chk(trim_offset[15:8], rnd[7:0]);
         chk(trim_gain, {rnd[11:8], rnd[15:8], rnd[7:0], 8'h00});
      end
      m_u.frame(1'b1, 2'h0, {5'h00, `ASCR_A_OFS_FINE}, 1, 1'b0);
      b = m_u.rbuf[0] + 8'h01;
      wr(`ASCR_A_OFS_FINE, b);
      chk(trim_offset[7:0], b);
      $display("test trims done");
      for (int k = 0; k < 4; k++) begin
         c = (k == 0) ? 3'h0 : 3'(1 << (k - 1));
         wr(`ASCR_A_PWR_SEL, {5'h00, c});
         wr(`ASCR_A_DIV_SEL, {5'h00, c});
         wr(`ASCR_A_DRV_CODE, {c, 2'h0, c});
         chk(ctrl.power_mode, pick(c, 3'h1));
         chk(ctrl.divide, pick(c, 3'h1));
         chk(ctrl.driver, pick(c, 3'h1));
         chk(ctrl.coding, pick(c, 3'h4));
      end
      wr(`ASCR_A_DIV_SEL, 8'h03);
      chk(ctrl.divide, 3'h4);
      wr(`ASCR_A_PWR_SEL, 8'h03);
      chk(ctrl.power_mode, 3'h4);
      // four-step nap entry
      wr(`ASCR_A_CONV_SEL, 8'h01);
      wr(`ASCR_A_PWR_SEL, 8'h02);
      wr(`ASCR_A_CONV_SEL, 8'h02);
      wr(`ASCR_A_PWR_SEL, 8'h02);
      chk(ctrl.power_mode, 3'h2);
      wr(`ASCR_A_PWR_SEL, 8'h01);
      chk(ctrl.power_mode, 3'h2);
      rchk(`ASCR_A_OFS_COARSE, `ASCR_ERR_BYTE);
      $display("test modes done");
      m_u.frame(1'b1, 2'h0, {5'h00, `ASCR_A_DDR_DLL}, 1, 1'b0);
      a = m_u.rbuf[0];
      rchk(`ASCR_A_CFG_STATE, cfg_state_in);
      b = a ^ cfg_state_in ^ 8'h40;
      wr(`ASCR_A_DDR_DLL, b);
      chk(ctrl.ddr_dll, b);
      chk(ctrl.dll_slow, b[`ASCR_B_DLL_SLOW]);
      wr(`ASCR_A_CLK_ADV, 8'h00);
      wr(`ASCR_A_CLK_ADV, 8'h01);
      chk(slips, 1);
      $display("test clock controls done");
      wr(`ASCR_A_BURST_LAST, `ASCR_A_PAT2_LO);
      rnd = lfsr(rnd);
      {m_u.wbuf[1], m_u.wbuf[0]} = rnd;
      rnd = lfsr(rnd);
      {m_u.wbuf[3], m_u.wbuf[2]} = rnd;
      u = {m_u.wbuf[1], m_u.wbuf[0], 8'h00, m_u.wbuf[2]};
      m_u.frame(1'b0, `ASCR_BC_MANY, {5'h00, `ASCR_A_PAT1_LO}, 3, 1'b0);
      m_u.frame(1'b1, 2'h1, {5'h00, `ASCR_A_PAT2_LO}, 2, 1'b0);
      chk({m_u.rbuf[0], m_u.rbuf[1]}, {u[7:0], 8'h00});
      foreach (tc[i]) begin
         wr(`ASCR_A_TEST_CTRL, tc[i]);
         repeat (4) @(posedge mclk);
         #1 wa = test_word;
         @(posedge mclk);
         #1 wb = test_word;
         chk(test_on, 1'b1);
         chk({wa, wb} === patw(tc[i], u) || {wb, wa} === patw(tc[i], u), 1'b1);
      end
      wr(`ASCR_A_TEST_CTRL, 8'h05);
      chk(test_word, u[31:16]);
      wr(`ASCR_A_TEST_CTRL, 8'h00);
      chk(test_on, 1'b0);
      $display("test patterns done");
      wr(`ASCR_A_PORT_CFG, 8'h5A);
      rchk(`ASCR_A_PORT_CFG, 8'h42, 1'b1);
      m_u.frame(1'b1, 2'h1, {5'h00, `ASCR_A_PAT1_HI}, 2, 1'b1);
      chk({m_u.rbuf[0], m_u.rbuf[1]}, u[31:16]);
      wr(`ASCR_A_PORT_CFG, 8'h99, 1'b1);
      {sdo_seen, sdio_seen} = 2'b00;
      rchk(`ASCR_A_PAT1_LO, u[23:16]);
      chk({sdo_seen, sdio_seen}, 2'b10);
      wr(`ASCR_A_PORT_CFG, 8'h3C);
      rchk(`ASCR_A_PORT_CFG, 8'h00);
      rchk(`ASCR_A_CONV_SEL, 8'h00);
      chk({ctrl.power_mode, ctrl.divide, ctrl.driver}, 9'h0A4);
      chk({trim_offset, ctrl.ddr_dll}, {cal.ofs_coarse, cal.ofs_fine, 8'h00});
      $display("test port modes done");
      conclude();
   end
endmodule : tb
`default_nettype wire
